// >>> logic/sdc_pkg.sv
// Constants, encodings and burst helpers for the SDRAM command and burst block.
// Assumes a single device clock; all pins are sampled on its rising edge.
`default_nettype none
package sdc_pkg;
  localparam int ROW_W = 13;
  localparam int COL_W = 11;
  localparam int BANKS = 4;
  localparam int MODE_W = 12;
  localparam int FULL_PAGE_COLS = 2048;
  localparam int WRQ_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 4;
  localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
  localparam int AUTO_PRECHARGE_BIT = 10;
  // Mode register field positions
  localparam int BURST_LENGTH_LSB = 0;
  localparam int BURST_TYPE_BIT = 3;
  localparam int READ_LATENCY_LSB = 4;
  localparam int OPERATING_MODE_LSB = 7;
  localparam int WRITE_BURST_MODE_BIT = 9;
  // Burst length and read latency codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] RL_2 = 3'h2;
  localparam logic [2:0] RL_3 = 3'h3;
  // Commands as {chip select, row strobe, column strobe, write enable}
  localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_TERMINATE = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  typedef enum logic [1:0] {BURST_IDLE, BURST_READ, BURST_WRITE} sdc_burst_t;

  // Column mask of one burst block; reserved codes act as a single access
  function automatic logic [COL_W-1:0] len_mask(input logic [2:0] bl);
    case (bl)
      BL_2: return 11'h001;
      BL_4: return 11'h003;
      BL_8: return 11'h007;
      BL_PAGE: return 11'h7ff;
      default: return 11'h000;
    endcase
  endfunction

  // Column of beat idx inside the block selected by start and mask
  function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] start, input logic [COL_W-1:0] idx,
                                                input logic [COL_W-1:0] m, input logic il);
    logic [COL_W-1:0] off;
    off = il ? (start ^ idx) : COL_W'(start + idx);
    return (start & ~m) | (off & m);
  endfunction
endpackage
`default_nettype wire

// >>> logic/sdc_top.sv
// SDRAM device-side command decoder, mode register, bank state and burst engine.
// Assumes a controller drives all command pins synchronously to CLK and keeps its own timing.
// Notes on behaviour
// - Burst of two: upper column bits pick block, bit zero picks start.
// - Burst of four: upper bits pick block, two low bits pick start.
// - Burst of eight: upper bits pick block, three low bits pick start.
// - A burst wraps inside its block instead of crossing the boundary.
// - Burst type bit chooses sequential or interleaved ordering.
// - Sequential adds index to start modulo length; interleaved XORs index with start.
// - Full-page burst runs sequentially over all row columns, wrapping, never interleaved.
// - Burst of one touches only the addressed column, ignoring burst type.
// - Read latency two or three; data valid by edge n plus latency.
// - Outputs start driving on the same edge as the first valid read data edge.
// - Write burst mode bit set makes every write a single access.
// - Commands decode from select, strobes and write enable; deselect inhibits all.
// - Clock enable high except self refresh; refresh encoding with it low enters self refresh.
// - Mode load takes opcode from address bits zero to eleven.
// - Activate opens the addressed row in the selected bank.
// - Read or write take column bits; auto-precharge bit applies to that command only.
// - Precharge closes the selected bank, or all banks when the bit is high.
// - Byte mask gates write data at once and read outputs two clocks later.
// - Deselected device takes no command; operations in progress finish.
// - Refresh uses the internal row counter and ignores address and data.
// - Mode register fields: length, type, latency, operating mode, write burst mode.
`timescale 1ns/100ps
`default_nettype none

module sdc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;

  assign out_valid = wr_q != rd_q;
  assign in_ready = wr_q != {~rd_q[PW], rd_q[PW-1:0]};
  assign out_data = mem[rd_q[PW-1:0]];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_q <= '0;
    end else if (in_valid && in_ready) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_q[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_q <= '0;
    end else if (out_valid && out_ready) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule // sdc_fifo

module sdc_top #(
  parameter int DQ_W = 8,
  parameter int MEM_RB = 2,
  parameter int MEM_CB = 6
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Command pins
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic BANK_SELECT_0,
  input wire logic BANK_SELECT_1,
  input wire logic [sdc_pkg::ROW_W-1:0] ADDR,
  // Data pins, split into input, output and per-byte output enable
  input wire logic [DQ_W/8-1:0] DQM,
  input wire logic [DQ_W-1:0] DQ_IN,
  output logic [DQ_W-1:0] DQ_OUT,
  output logic [DQ_W/8-1:0] DQ_OE,
  // Status
  output logic [sdc_pkg::MODE_W-1:0] MODE_VALUE,
  output logic [sdc_pkg::BANKS-1:0] BANK_OPEN,
  output logic [sdc_pkg::ROW_W-1:0] REFRESH_ROW,
  output logic SELF_REFRESH,
  output logic BURST_ACTIVE,
  output logic WRQ_READY
);
  localparam int DQM_W = DQ_W / 8;
  localparam int MEM_AW = 2 + MEM_RB + MEM_CB;
  localparam int WQ_W = MEM_AW + DQM_W + DQ_W;
  localparam int CW = sdc_pkg::COL_W;

  logic [sdc_pkg::MODE_W-1:0] mode_q;
  logic [sdc_pkg::BANKS-1:0] open_q;
  logic [sdc_pkg::ROW_W-1:0] row_q [sdc_pkg::BANKS];
  logic [sdc_pkg::ROW_W-1:0] ref_q;
  logic sref_q;
  sdc_pkg::sdc_burst_t st_q;
  logic [CW-1:0] start_q, idx_q, mask_q;
  logic il_q, ap_q;
  logic [1:0] bank_q;
  logic [DQ_W-1:0] s1_q, dq_q;
  logic s1v_q, outv_q;
  logic [DQM_W-1:0] dqm1_q, oe_q;
  logic [DQ_W-1:0] mem [2**MEM_AW];

  logic [3:0] cmd;
  logic take;
  assign cmd = {CS_N, RAS_N, CAS_N, WE_N};
  assign take = CKE && !CS_N;
  logic cmd_act, cmd_rd, cmd_wr, cmd_bst, cmd_pre, cmd_ref, cmd_sref, cmd_mrs;
  assign cmd_act = take && cmd == sdc_pkg::CMD_ACTIVATE;
  assign cmd_rd = take && cmd == sdc_pkg::CMD_READ;
  assign cmd_wr = take && cmd == sdc_pkg::CMD_WRITE;
  assign cmd_bst = take && cmd == sdc_pkg::CMD_TERMINATE;
  assign cmd_pre = take && cmd == sdc_pkg::CMD_PRECHARGE;
  assign cmd_mrs = take && cmd == sdc_pkg::CMD_MODE_LOAD;
  assign cmd_ref = take && cmd == sdc_pkg::CMD_REFRESH;
  assign cmd_sref = !CKE && !CS_N && cmd == sdc_pkg::CMD_REFRESH && !sref_q;

  logic [1:0] bank;
  logic [CW-1:0] col_in;
  assign bank = {BANK_SELECT_1, BANK_SELECT_0};
  assign col_in = {ADDR[11], ADDR[9:0]};

  logic [2:0] bl, rl;
  logic bt, wbm;
  assign bl = mode_q[sdc_pkg::BURST_LENGTH_LSB +: 3];
  assign bt = mode_q[sdc_pkg::BURST_TYPE_BIT];
  assign rl = mode_q[sdc_pkg::READ_LATENCY_LSB +: 3];
  assign wbm = mode_q[sdc_pkg::WRITE_BURST_MODE_BIT];

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      mode_q <= sdc_pkg::MODE_RESET;
    end else if (cmd_mrs) begin
      mode_q <= ADDR[sdc_pkg::MODE_W-1:0];
    end
  end

  logic [CW-1:0] rd_mask, wr_mask, new_mask;
  assign rd_mask = sdc_pkg::len_mask(bl);
  assign wr_mask = wbm ? '0 : rd_mask;
  assign new_mask = cmd_rd ? rd_mask : wr_mask;

  logic page, burst_last, burst_end, ap_end, wr_now_ap;
  logic [CW-1:0] cur_col;
  assign page = &mask_q;
  assign burst_last = idx_q == mask_q && !page;
  assign burst_end = st_q != sdc_pkg::BURST_IDLE && burst_last && !(cmd_rd || cmd_wr || cmd_bst);
  assign ap_end = burst_end && ap_q;
  assign wr_now_ap = cmd_wr && wr_mask == '0 && ADDR[sdc_pkg::AUTO_PRECHARGE_BIT];
  assign cur_col = sdc_pkg::beat_col(start_q, idx_q, mask_q, il_q);
  assign BURST_ACTIVE = st_q != sdc_pkg::BURST_IDLE;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st_q <= sdc_pkg::BURST_IDLE;
      start_q <= '0;
      idx_q <= '0;
      mask_q <= '0;
      il_q <= 1'b0;
      ap_q <= 1'b0;
      bank_q <= '0;
    end else if (cmd_rd || cmd_wr) begin
      // A new access cuts off any burst in flight; write beat zero lands now
      st_q <= cmd_rd ? sdc_pkg::BURST_READ : (wr_mask == '0 ? sdc_pkg::BURST_IDLE : sdc_pkg::BURST_WRITE);
      idx_q <= cmd_rd ? 11'h000 : 11'h001;
      start_q <= col_in;
      mask_q <= new_mask;
      il_q <= bt && !(&new_mask);
      ap_q <= ADDR[sdc_pkg::AUTO_PRECHARGE_BIT] && !(&new_mask);
      bank_q <= bank;
    end else if (cmd_bst) begin
      st_q <= sdc_pkg::BURST_IDLE;
    end else begin
      unique case (st_q)
        sdc_pkg::BURST_IDLE: begin
          idx_q <= idx_q;
        end
        sdc_pkg::BURST_READ, sdc_pkg::BURST_WRITE: begin
          // page burst runs on until cut off
          if (burst_last) begin
            st_q <= sdc_pkg::BURST_IDLE;
          end
          idx_q <= CW'(idx_q + 11'h001);
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      open_q <= '0;
      for (int b = 0; b < sdc_pkg::BANKS; b++) begin
        row_q[b] <= '0;
      end
    end else begin
      if (ap_end) begin
        open_q[bank_q] <= 1'b0;
      end
      if (wr_now_ap) begin
        open_q[bank] <= 1'b0;
      end
      if (cmd_act) begin
        open_q[bank] <= 1'b1;
        row_q[bank] <= ADDR;
      end
      if (cmd_pre) begin
        if (ADDR[sdc_pkg::AUTO_PRECHARGE_BIT]) begin
          open_q <= '0;
        end else begin
          open_q[bank] <= 1'b0;
        end
      end
    end
  end
  assign BANK_OPEN = open_q;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ref_q <= '0;
    end else if (cmd_ref || cmd_sref) begin
      ref_q <= sdc_pkg::ROW_W'(ref_q + 13'h0001);
    end
  end

  // Exit sequencing is left to the controller; raising the clock enable ends it here
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      sref_q <= 1'b0;
    end else if (cmd_sref) begin
      sref_q <= 1'b1;
    end else if (CKE) begin
      sref_q <= 1'b0;
    end
  end
  assign REFRESH_ROW = ref_q;
  assign SELF_REFRESH = sref_q;
  assign MODE_VALUE = mode_q;

  // Write path: beats queue up so the single array port can favour reads
  logic rd_beat, wr_beatn, q_valid, q_pop, push;
  logic [MEM_AW-1:0] rd_addr, push_addr, q_addr;
  logic [WQ_W-1:0] q_data;
  assign rd_beat = st_q == sdc_pkg::BURST_READ;
  assign wr_beatn = st_q == sdc_pkg::BURST_WRITE && !(cmd_rd || cmd_wr || cmd_bst);
  assign push = cmd_wr || wr_beatn;
  assign rd_addr = {bank_q, row_q[bank_q][MEM_RB-1:0], cur_col[MEM_CB-1:0]};
  assign push_addr = cmd_wr ? {bank, row_q[bank][MEM_RB-1:0], col_in[MEM_CB-1:0]} : rd_addr;
  assign q_pop = q_valid && !rd_beat;
  assign q_addr = q_data[WQ_W-1 -: MEM_AW];

  // A full queue drops the beat; WRQ_READY tells the system it happened
  sdc_fifo #(.W(WQ_W), .DEPTH(sdc_pkg::WRQ_DEPTH)) u_wrq (
    .clk(CLK),
    .resetn(RESETN),
    .in_valid(push),
    .in_ready(WRQ_READY),
    .in_data({push_addr, DQM, DQ_IN}),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .out_data(q_data)
  );

  always_ff @(posedge CLK) begin
    for (int l = 0; l < DQM_W; l++) begin
      if (q_pop && !q_data[DQ_W + l]) begin
        mem[q_addr][l*8 +: 8] <= q_data[l*8 +: 8];
      end
    end
  end

  logic rl3, outv_d;
  logic [DQ_W-1:0] mem_rd;
  assign rl3 = rl == sdc_pkg::RL_3;
  assign mem_rd = mem[rd_addr];
  assign outv_d = rl3 ? s1v_q : rd_beat;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      s1_q <= '0;
      s1v_q <= 1'b0;
      dq_q <= '0;
      outv_q <= 1'b0;
    end else begin
      s1_q <= mem_rd;
      s1v_q <= rd_beat;
      dq_q <= rl3 ? s1_q : mem_rd;
      outv_q <= outv_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      dqm1_q <= '0;
      oe_q <= '0;
    end else begin
      dqm1_q <= DQM;
      oe_q <= {DQM_W{outv_d}} & ~dqm1_q;
    end
  end
  assign DQ_OUT = dq_q;
  assign DQ_OE = oe_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_mode_load_capture: assert property (
    cmd_mrs |=> MODE_VALUE == $past(ADDR[11:0])) else $error("mode opcode not captured");
  a_inhibit_hold_state: assert property (
    CS_N |=> MODE_VALUE == $past(MODE_VALUE) && REFRESH_ROW == $past(REFRESH_ROW))
    else $error("deselected device changed state");
  a_activate_opens_row: assert property (
    cmd_act |=> BANK_OPEN[$past(bank)] && row_q[$past(bank)] == $past(ADDR)) else $error("row not opened");
  a_precharge_all_banks: assert property (
    cmd_pre && ADDR[10] |=> BANK_OPEN == '0) else $error("precharge all left a bank open");
  a_write_single_access: assert property (
    cmd_wr && wbm |=> st_q == sdc_pkg::BURST_IDLE) else $error("write burst in single mode");
  a_wrap_in_block: assert property (
    BURST_ACTIVE |-> (cur_col & ~mask_q) == (start_q & ~mask_q)) else $error("burst left its block");
  a_interleave_order: assert property (
    BURST_ACTIVE && il_q |-> ((cur_col ^ start_q) & mask_q) == (idx_q & mask_q))
    else $error("interleaved order wrong");
  a_sequential_step: assert property (
    rd_beat && !il_q && !burst_last && !cmd_rd && !cmd_wr && !cmd_bst
    |=> (cur_col & mask_q) == (CW'($past(cur_col) + 11'h001) & mask_q)) else $error("sequential step wrong");
  a_single_beat_read: assert property (
    (cmd_rd && bl == sdc_pkg::BL_1) ##1 !(cmd_rd || cmd_wr) |=> st_q == sdc_pkg::BURST_IDLE)
    else $error("burst of one ran long");
  a_latency_two_data: assert property (
    cmd_rd && rl == sdc_pkg::RL_2 |-> ##2 outv_q) else $error("latency two data late");
  a_latency_three_data: assert property (
    cmd_rd && rl3 && st_q == sdc_pkg::BURST_IDLE |-> ##2 !outv_q ##1 outv_q) else $error("latency three timing");
  a_read_mask_delay: assert property (
    outv_q |-> DQ_OE == ~$past(DQM, 2)) else $error("read mask delay wrong");
  a_refresh_counts: assert property (
    cmd_ref || cmd_sref |=> REFRESH_ROW == sdc_pkg::ROW_W'($past(REFRESH_ROW) + 13'h0001))
    else $error("refresh counter did not step");

  c_read_latency_three: cover property (cmd_rd && rl3 ##3 outv_q);
  c_write_burst_eight: cover property (cmd_wr && bl == sdc_pkg::BL_8 && !wbm);
  c_page_terminated: cover property (BURST_ACTIVE && page ##1 cmd_bst);
  c_self_refresh_entry: cover property (cmd_sref);
endmodule // sdc_top
`default_nettype wire

// >>> verif/sdc_ctrl_model.sv
// Memory controller model driving the command, mask and write data pins.
// Assumes one call of cmd per clock; pins change by non-blocking assignment at CLK rise.
`timescale 1ns/100ps
`default_nettype none
module sdc_ctrl_model (
  // Clock
  input wire logic clk,
  // Command pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bank,
  output logic [sdc_pkg::ROW_W-1:0] addr,
  // Data pins
  output logic dqm,
  output logic [7:0] dq
);
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = sdc_pkg::CMD_NOP;
    bank = 2'h0;
    addr = 13'h0000;
    dqm = 1'b0;
    dq = 8'h5a;
  end

  // clock enable high except self refresh
  task automatic cmd(input logic [3:0] code, input logic [1:0] b, input logic [12:0] a,
                     input logic m, input logic [7:0] d, input logic ce = 1'b1);
    @(posedge clk);
    cke <= ce;
    {cs_n, ras_n, cas_n, we_n} <= code;
    bank <= b;
    addr <= (code == sdc_pkg::CMD_MODE_LOAD) ? {1'b0, a[11:0]} : a;
    dqm <= m;
    dq <= d;
  endtask

  // latency choice left to the caller
  task automatic load_mode(input logic [2:0] bl, input logic il, input logic [2:0] rl, input logic wbm);
    cmd(sdc_pkg::CMD_PRECHARGE, 2'h0, 13'h0400, 1'b0, ~dq);
    cmd(sdc_pkg::CMD_MODE_LOAD, 2'h0, {3'h0, wbm, 2'h0, rl, il, bl}, 1'b0, ~dq);
    cmd(sdc_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b0, ~dq);
    cmd(sdc_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b0, ~dq);
    cmd(sdc_pkg::CMD_ACTIVATE, 2'h0, 13'h0000, 1'b0, ~dq);
  endtask
endmodule // sdc_ctrl_model
`default_nettype wire

// >>> verif/sdram_command_and_burst_mode_tb.sv
// Self-checking bench: burst order, latency, masks and command effects against a reference memory model.
// Assumes the controller model drives every command and data input; bank 0 row 0 holds the test data.
`timescale 1ns/100ps
`default_nettype none
module sdram_command_and_burst_mode_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n, dqm;
  logic [1:0] bank;
  logic [12:0] addr;
  logic [7:0] dq, dq_out;
  logic [0:0] dq_oe;
  logic [11:0] mode_value;
  logic [3:0] bank_open;
  logic [12:0] refresh_row, r;
  logic self_refresh, burst_active, wrq_ready;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h0460;
  logic [7:0] mem [int];

  always #2 clk = ~clk;

  sdc_ctrl_model i_sdc_ctrl_model (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank(bank), .addr(addr), .dqm(dqm), .dq(dq));

  sdc_top i_sdc_top (.CLK(clk), .RESETN(resetn), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n),
    .WE_N(we_n), .BANK_SELECT_0(bank[0]), .BANK_SELECT_1(bank[1]), .ADDR(addr), .DQM(dqm), .DQ_IN(dq),
    .DQ_OUT(dq_out), .DQ_OE(dq_oe), .MODE_VALUE(mode_value), .BANK_OPEN(bank_open),
    .REFRESH_ROW(refresh_row), .SELF_REFRESH(self_refresh), .BURST_ACTIVE(burst_active),
    .WRQ_READY(wrq_ready));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Column of beat k, folded onto the six column bits the storage keeps
  function automatic int colk(int st, int k, int len, logic il);
    int off;
    off = il ? (st ^ k) : (st + k);
    return ((st & ~(len - 1)) | (off & (len - 1))) & 63;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic nop(input int n);
    repeat (n) i_sdc_ctrl_model.cmd(sdc_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b0, 8'(rnd()));
  endtask

  task automatic op(input logic [3:0] code, input logic [1:0] b, input logic [12:0] a);
    i_sdc_ctrl_model.cmd(code, b, a, 1'b0, 8'(rnd()));
    nop(1);
    #1;
  endtask

  // Write a burst, let the queue drain, read it back beat by beat
  task automatic burst(input logic [2:0] code, input int len, input int beats, input logic il,
                       input logic [2:0] rl, input logic wbm, input logic ap);
    int st;
    int m;
    logic [7:0] d;
    logic msk;
    st = int'(rnd() & 32'h3f);
    m = (rl == sdc_pkg::RL_3) ? 3 : 2;
    i_sdc_ctrl_model.load_mode(code, il, rl, wbm);
    #1;
    chk(16'(mode_value), 16'({2'b00, wbm, 2'b00, rl, il, code}));
    for (int k = 0; k < beats; k++) begin
      d = 8'(rnd());
      msk = (code != sdc_pkg::BL_PAGE) & 1'(rnd());
      i_sdc_ctrl_model.cmd(k == 0 ? sdc_pkg::CMD_WRITE : sdc_pkg::CMD_NOP, 2'h0,
                           k == 0 ? (13'(st) | {2'b00, ap, 10'h000}) : 13'h0000, msk, d);
      if (!msk && (k == 0 || !wbm)) mem[colk(st, k, len, il)] = d;
      if (k == 1) begin
        #1;
        chk(16'(burst_active), 16'(!wbm));
      end
    end
    i_sdc_ctrl_model.cmd(sdc_pkg::CMD_TERMINATE, 2'h0, 13'h0000, 1'b0, 8'(rnd()));
    nop(20);
    #1;
    chk(16'(bank_open[0]), 16'(!ap));
    // Auto precharge after the write closed the row; reopen it for the read back
    if (ap) begin
      i_sdc_ctrl_model.cmd(sdc_pkg::CMD_ACTIVATE, 2'h0, 13'h0000, 1'b0, 8'(rnd()));
    end
    i_sdc_ctrl_model.cmd(sdc_pkg::CMD_READ, 2'h0, 13'(st) | {2'b00, ap, 10'h000}, 1'b0, 8'(rnd()));
    for (int j = 1; j < m + beats; j++) begin
      nop(1);
      #1;
      if (j >= m) chk({dq_oe, dq_out}, {1'b1, mem[colk(st, j - m, len, il)]});
    end
    if (code == sdc_pkg::BL_PAGE) begin
      i_sdc_ctrl_model.cmd(sdc_pkg::CMD_TERMINATE, 2'h0, 13'h0000, 1'b0, 8'(rnd()));
    end else begin
      nop(1);
      #1;
      chk(16'(dq_oe), 16'h0000);
      nop(3);
      #1;
      chk(16'(bank_open[0]), 16'(!ap));
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk({mode_value, burst_active, wrq_ready}, 16'h0001);
    // Page burst fills all 64 kept columns without reaching the row end
    burst(sdc_pkg::BL_PAGE, 2048, 64, 1'b0, sdc_pkg::RL_3, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++) begin
      burst(3'(i >> 2), 1 << (i >> 2), 1 << (i >> 2), 1'(i), 3'(2 + ((i >> 1) & 1)),
            1'(rnd()), 1'(rnd()));
    end
    burst(sdc_pkg::BL_PAGE, 2048, 8, 1'b0, sdc_pkg::RL_2, 1'b0, 1'b0);
    i_sdc_ctrl_model.load_mode(sdc_pkg::BL_4, 1'b0, sdc_pkg::RL_2, 1'b0);
    i_sdc_ctrl_model.cmd(sdc_pkg::CMD_READ, 2'h0, 13'h0000, 1'b1, 8'(rnd()));
    nop(2);
    #1;
    chk(16'(dq_oe), 16'h0000);
    nop(1);
    #1;
    chk(16'(dq_oe), 16'h0001);
    nop(4);
    op(4'hb, 2'h2, 13'h0005);
    chk(16'(bank_open), 16'h0001);
    op(sdc_pkg::CMD_ACTIVATE, 2'h2, 13'h0005);
    chk(16'(bank_open), 16'h0005);
    op(sdc_pkg::CMD_PRECHARGE, 2'h2, 13'h0000);
    chk(16'(bank_open), 16'h0001);
    op(sdc_pkg::CMD_PRECHARGE, 2'h1, 13'h0400);
    chk(16'(bank_open), 16'h0000);
    r = refresh_row;
    op(sdc_pkg::CMD_REFRESH, 2'h3, 13'h1fff);
    chk(16'(refresh_row), 16'(r + 13'h0001));
    chk(16'(bank_open), 16'h0000);
    i_sdc_ctrl_model.cmd(sdc_pkg::CMD_REFRESH, 2'h0, 13'h0000, 1'b0, 8'h00, 1'b0);
    i_sdc_ctrl_model.cmd(sdc_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b0, 8'hff, 1'b0);
    #1;
    chk(16'(self_refresh), 16'h0001);
    nop(2);
    #1;
    chk(16'(self_refresh), 16'h0000);
    test_done();
  end
endmodule // sdram_command_and_burst_mode_tb
`default_nettype wire
